// File: hdl/pism_pkg.sv
package pism_pkg;

    localparam int WORDS  = 4;
    localparam int CORES  = 2;
    localparam int DW     = 32;
    localparam int SRC_W  = WORDS * DW;
    localparam int CODE_W = 12;
    localparam int EV_W   = 4;

    // bits that carry a source in each word; everything else is reserved
    localparam logic [DW-1:0] VALID_W0 = 32'h0000_0001;
    localparam logic [DW-1:0] VALID_W1 = 32'hFFFF_FFFF;
    localparam logic [DW-1:0] VALID_W2 = 32'h3F00_01FF;
    localparam logic [DW-1:0] VALID_W3 = 32'hFFFF_FF00;
    localparam logic [WORDS-1:0][DW-1:0] VALID_BITS =
        {VALID_W3, VALID_W2, VALID_W1, VALID_W0};

    localparam logic [DW-1:0] MASK_RESET = 32'hFFFF_FFFF;
    localparam logic [DW-1:0] ZERO_WORD  = 32'h0000_0000;

    // byte addresses inside one core set, then the core stride
    localparam logic [7:0] OFS_RAW     = 8'h00;
    localparam logic [7:0] OFS_MASKED  = 8'h10;
    localparam logic [7:0] OFS_MASK    = 8'h20;
    localparam logic [7:0] OFS_CLR     = 8'h30;
    localparam logic [7:0] CORE_STRIDE = 8'h40;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h80;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h84;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h88;
    localparam logic [7:0] GROUP_SPAN  = 8'h10;

    localparam logic [CODE_W-1:0] CODE_WORD_STEP = 12'h400;
    localparam logic [CODE_W-1:0] CODE_BIT_STEP  = 12'h020;

    // interrupt status bit positions
    localparam int EV_NOTIFY0 = 0;
    localparam int EV_NOTIFY1 = 1;
    localparam int EV_BADADDR = 2;
    localparam int EV_ROWRITE = 3;

    typedef enum logic [2:0] {
        GRP_RAW     = 3'b000,
        GRP_MASKED  = 3'b001,
        GRP_MASK    = 3'b010,
        GRP_CLR     = 3'b011,
        GRP_IRQ_ST  = 3'b100,
        GRP_IRQ_CLR = 3'b101,
        GRP_IRQ_EN  = 3'b110,
        GRP_NONE    = 3'b111
    } pism_grp_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ANSWER = 2'b01
    } pism_apb_st_t;

    // code = word * 0x400 + (31 - bit) * 0x20
    function automatic logic [CODE_W-1:0] event_code(input int w,
                                                     input int b);
        logic [CODE_W-1:0] wc;
        logic [CODE_W-1:0] bc;
        wc = CODE_W'(w) * CODE_WORD_STEP;
        bc = CODE_W'(DW - 1 - b) * CODE_BIT_STEP;
        return CODE_W'(wc + bc);
    endfunction

    function automatic logic [DW-1:0] strb_expand(input logic [3:0] s);
        logic [DW-1:0] m;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

endpackage

// File: hdl/pism_mask_bank.sv
`timescale 1ns/1ps
module pism_mask_bank
    import pism_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   ce,
    input  wire logic                   set_en,
    input  wire logic                   clr_en,
    input  wire logic [1:0]             word_sel,
    input  wire logic [pism_pkg::DW-1:0] wdata,
    output logic [pism_pkg::SRC_W-1:0]  mask_q
);
    logic [WORDS-1:0][DW-1:0] mask_r;
    logic [WORDS-1:0][DW-1:0] mask_d;

    always_comb begin
        mask_d = mask_r;
        for (int w = 0; w < WORDS; w++) begin
            if (word_sel == 2'(w)) begin
                // ones set (set_en) or clear (clr_en), zeros leave the bit alone; reserved bits untouched
                if (set_en) begin
                    mask_d[w] = mask_r[w] | (wdata & VALID_BITS[w]);
                end else if (clr_en) begin
                    mask_d[w] = mask_r[w] & ~(wdata & VALID_BITS[w]);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= {WORDS{MASK_RESET}};
        end else if (ce) begin
            mask_r <= mask_d;
        end
    end

    assign mask_q = mask_r;

endmodule

// File: hdl/pism_top.sv
`timescale 1ns/1ps
module pism_top
    import pism_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        ce,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [pism_pkg::DW-1:0]     pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic                             pready,
    output logic [pism_pkg::DW-1:0]          prdata,
    output logic                             pslverr,
    input  wire logic [pism_pkg::SRC_W-1:0]  src_req,
    input  wire logic [pism_pkg::SRC_W-1:0]  ack_mask_0,
    input  wire logic [pism_pkg::SRC_W-1:0]  ack_mask_1,
    output logic                             notify_0,
    output logic                             notify_1,
    output logic [pism_pkg::CODE_W-1:0]      event_vector_code_0,
    output logic [pism_pkg::CODE_W-1:0]      event_vector_code_1,
    output logic                             irq
);
    import pism_pkg::*;

    // the decoder, the word field and the fixed port set need these sizes
    if (ADDR_W < 8) begin : g_chk_addr
        $error("pism_top: ADDR_W must be at least 8");
    end
    if (CORES != 2) begin : g_chk_cores
        $error("pism_top: exactly two cores are served");
    end
    if (WORDS != 4 || DW != 32) begin : g_chk_words
        $error("pism_top: four 32-bit source words expected");
    end
    if (CODE_W < 12) begin : g_chk_code
        $error("pism_top: event codes need at least 12 bits");
    end
    if (EV_W <= EV_ROWRITE) begin : g_chk_ev
        $error("pism_top: status too narrow for its events");
    end

    // address decode: register group, core, word inside the group
    typedef struct packed {
        pism_grp_t  grp;
        logic       core;
        logic [1:0] word;
    } pism_dec_t;

    function automatic pism_dec_t decode(input logic [ADDR_W-1:0] a);
        pism_dec_t  r;
        logic [7:0] lo;
        logic [7:0] in_core;
        r.grp   = GRP_NONE;
        r.core  = 1'b0;
        r.word  = a[3:2];
        lo      = a[7:0];
        in_core = lo;
        // misaligned or out-of-map addresses answer with an error
        if (a[1:0] != 2'b00 || (ADDR_W > 8 && (a >> 8) != '0)) begin
            r.grp = GRP_NONE;
        end else if (lo == OFS_IRQ_ST) begin
            r.grp = GRP_IRQ_ST;
        end else if (lo == OFS_IRQ_CLR) begin
            r.grp = GRP_IRQ_CLR;
        end else if (lo == OFS_IRQ_EN) begin
            r.grp = GRP_IRQ_EN;
        end else if (lo < 8'(CORES) * CORE_STRIDE) begin
            if (lo >= CORE_STRIDE) begin
                r.core  = 1'b1;
                in_core = 8'(lo - CORE_STRIDE);
            end
            if (in_core < OFS_MASKED) begin
                r.grp = GRP_RAW;
            end else if (in_core < OFS_MASK) begin
                r.grp = GRP_MASKED;
            end else if (in_core < OFS_CLR) begin
                r.grp = GRP_MASK;
            end else if (in_core < 8'(OFS_CLR + GROUP_SPAN)) begin
                r.grp = GRP_CLR;
            end
        end
        return r;
    endfunction

    logic [SRC_W-1:0] valid_flat;
    assign valid_flat = VALID_BITS;

    // per-core mask banks and pending views
    logic [CORES-1:0][SRC_W-1:0] mask_w;
    logic [CORES-1:0][SRC_W-1:0] ack_w;
    logic [CORES-1:0][SRC_W-1:0] pend_w;
    logic [CORES-1:0]            set_en;
    logic [CORES-1:0]            clr_en;

    assign ack_w[0] = ack_mask_0;
    assign ack_w[1] = ack_mask_1;

    // interrupt status, clear and enable
    logic [EV_W-1:0] irq_st_q;
    logic [EV_W-1:0] irq_st_d;
    logic [EV_W-1:0] irq_en_q;
    logic [EV_W-1:0] irq_en_d;
    logic            irq_q;
    logic            irq_d;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    // APB handshake
    pism_apb_st_t     st_q;
    pism_apb_st_t     st_d;
    logic             pready_q;
    logic             pready_d;
    logic [DW-1:0]    prdata_q;
    logic [DW-1:0]    prdata_d;
    logic             pslverr_q;
    logic             pslverr_d;
    logic             setup;
    logic             done;
    pism_dec_t        rd_dec;
    pism_dec_t        wr_dec;
    logic [DW-1:0]    wr_bits;

    // pready is registered off the setup edge: one access cycle, no waits
    assign setup   = psel && !penable && (st_q == ST_IDLE);
    assign done    = psel && penable && pready_q;
    assign rd_dec  = decode(paddr);
    assign wr_dec  = decode(paddr);
    assign wr_bits = pwdata & strb_expand(pstrb);

    // accesses that touch the interrupt register set
    logic irq_clr_wr;
    logic irq_en_wr;
    logic ro_wr;
    logic bad_acc;

    assign irq_clr_wr = done && pwrite && (wr_dec.grp == GRP_IRQ_CLR);
    assign irq_en_wr  = done && pwrite && (wr_dec.grp == GRP_IRQ_EN);
    // writes to read-only words only flag the attempt
    assign ro_wr      = done && pwrite
                        && (wr_dec.grp == GRP_RAW
                            || wr_dec.grp == GRP_MASKED
                            || wr_dec.grp == GRP_IRQ_ST);
    assign bad_acc    = done && (wr_dec.grp == GRP_NONE);

    genvar gc;
    generate
        for (gc = 0; gc < CORES; gc++) begin : g_core
            assign set_en[gc] = done && pwrite && (wr_dec.grp == GRP_MASK)
                                && (wr_dec.core == 1'(gc));
            assign clr_en[gc] = done && pwrite && (wr_dec.grp == GRP_CLR)
                                && (wr_dec.core == 1'(gc));

            pism_mask_bank u_bank (
                .clk      (clk),
                .arst_n   (arst_n),
                .ce       (ce),
                .set_en   (set_en[gc]),
                .clr_en   (clr_en[gc]),
                .word_sel (wr_dec.word),
                .wdata    (wr_bits),
                .mask_q   (mask_w[gc])
            );

            // masked and acknowledged sources drop out
            assign pend_w[gc] = src_req & ~mask_w[gc] & ~ack_w[gc]
                                & valid_flat;
        end
    endgenerate

    // read data, taken from live mask state at the setup edge
    always_comb begin
        logic [DW-1:0] raw_word;
        logic [DW-1:0] vmask;
        raw_word  = src_req[rd_dec.word*DW +: DW];
        vmask     = VALID_BITS[rd_dec.word];
        st_d      = st_q;
        pready_d  = pready_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        case (st_q)
            ST_IDLE: begin
                if (setup) begin
                    st_d      = ST_ANSWER;
                    pready_d  = 1'b1;
                    pslverr_d = (rd_dec.grp == GRP_NONE);
                    // clear words and unmapped read zero
                    prdata_d  = ZERO_WORD;
                    if (!pwrite) begin
                        if (rd_dec.grp == GRP_RAW) begin
                            prdata_d = raw_word & vmask;
                        end else if (rd_dec.grp == GRP_MASKED) begin
                            prdata_d =
                                pend_w[rd_dec.core][rd_dec.word*DW +: DW];
                        end else if (rd_dec.grp == GRP_MASK) begin
                            prdata_d =
                                mask_w[rd_dec.core][rd_dec.word*DW +: DW]
                                & vmask;
                        end else if (rd_dec.grp == GRP_IRQ_ST) begin
                            prdata_d = DW'(irq_st_q);
                        end else if (rd_dec.grp == GRP_IRQ_EN) begin
                            prdata_d = DW'(irq_en_q);
                        end
                    end
                end
            end
            ST_ANSWER: begin
                if (done) begin
                    st_d      = ST_IDLE;
                    pready_d  = 1'b0;
                    pslverr_d = 1'b0;
                end
            end
            default: begin
                st_d     = ST_IDLE;
                pready_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q      <= ST_IDLE;
            pready_q  <= 1'b0;
            prdata_q  <= ZERO_WORD;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            st_q      <= st_d;
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // notification and first pending event code per core
    logic [CORES-1:0]             notify_q;
    logic [CORES-1:0]             notify_d;
    logic [CORES-1:0][CODE_W-1:0] code_q;
    logic [CORES-1:0][CODE_W-1:0] code_d;

    always_comb begin
        for (int c = 0; c < CORES; c++) begin
            notify_d[c] = |pend_w[c];
            // code holds its last value while nothing is pending
            code_d[c]   = code_q[c];
            for (int w = WORDS - 1; w >= 0; w--) begin
                for (int b = 0; b < DW; b++) begin
                    if (pend_w[c][w*DW + b]) begin
                        code_d[c] = event_code(w, b);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            notify_q <= '0;
            code_q   <= '0;
        end else if (ce) begin
            notify_q <= notify_d;
            code_q   <= code_d;
        end
    end

    // a standing source counts once, on the rise of its notify level
    logic [CORES-1:0] notify_rise;
    assign notify_rise = notify_d & ~notify_q;

    always_comb begin
        ev_set             = '0;
        ev_set[EV_NOTIFY0] = notify_rise[0];
        ev_set[EV_NOTIFY1] = notify_rise[1];
        ev_set[EV_BADADDR] = bad_acc;
        ev_set[EV_ROWRITE] = ro_wr;
        ev_clr = '0;
        if (irq_clr_wr) begin
            ev_clr = wr_bits[EV_W-1:0];
        end
        irq_en_d = irq_en_q;
        if (irq_en_wr) begin
            irq_en_d = wr_bits[EV_W-1:0];
        end
        // a new event outweighs a clear in the same cycle
        irq_st_d = (irq_st_q & ~ev_clr) | ev_set;
        irq_d    = |(irq_st_d & irq_en_d);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
            irq_q    <= 1'b0;
        end else if (ce) begin
            irq_st_q <= irq_st_d;
            irq_en_q <= irq_en_d;
            irq_q    <= irq_d;
        end
    end

    assign pready              = pready_q;
    assign prdata              = prdata_q;
    assign pslverr             = pslverr_q;
    assign notify_0            = notify_q[0];
    assign notify_1            = notify_q[1];
    assign event_vector_code_0 = code_q[0];
    assign event_vector_code_1 = code_q[1];
    assign irq                 = irq_q;

endmodule

// File: verification/pism_top_sva.sv
`timescale 1ns/1ps
module pism_top_chk
    import pism_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic [DW-1:0]     prdata,
    input wire logic [SRC_W-1:0]  src_req,
    input wire logic [SRC_W-1:0]  ack_mask_0,
    input wire logic              notify_0,
    input wire logic              notify_1
);
    wire       go  = ce && psel && !penable;
    wire       rgo = go && !pwrite;
    wire [7:0] adr = paddr[7:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_answer;
        go |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("bad answer");
    property p_raw1;
        rgo && adr == 8'h04 |=> prdata == $past(src_req[63:32]);
    endproperty
    a_raw1: assert property (p_raw1) else $error("raw word 1");
    property p_raw3;
        rgo && adr == 8'h0C |=> prdata == ($past(src_req[127:96]) & VALID_W3);
    endproperty
    a_raw3: assert property (p_raw3) else $error("raw word 3");
    property p_raw0;
        rgo && adr == 8'h00 |=> prdata == {31'h0, $past(src_req[0])};
    endproperty
    a_raw0: assert property (p_raw0) else $error("raw word 0");
    property p_clr_rd;
        rgo && adr[7:4] == 4'h3 |=> prdata == ZERO_WORD;
    endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear read");
    property p_ack_rd;
        rgo && adr == 8'h1C && &ack_mask_0 |=> prdata == ZERO_WORD;
    endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("ack read");
    property p_ack_nt;
        &ack_mask_0 |=> !notify_0;
    endproperty
    a_ack_nt: assert property (p_ack_nt) else $error("ack notify");
    property p_quiet;
        src_req == '0 |=> !notify_0 && !notify_1;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle notify");
endmodule

bind pism_top pism_top_chk #(.ADDR_W(ADDR_W)) pism_top_chk_inst (
    .clk(clk), .arst_n(arst_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready),
    .prdata(prdata), .src_req(src_req), .ack_mask_0(ack_mask_0),
    .notify_0(notify_0), .notify_1(notify_1)
);

// File: verification/pism_periph_model.sv
`timescale 1ns/1ps
module pism_periph_model
    import pism_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [SRC_W-1:0] raise,
    input  wire logic [SRC_W-1:0] det_en,
    output logic      [SRC_W-1:0] src_req
);
    logic [SRC_W-1:0] pend_q;
    always_ff @(posedge clk) begin
        pend_q <= raise;
    end
    // detail gating
    // detail causes only maskable inside the peripheral
    assign src_req = pend_q & det_en;
endmodule

// File: verification/pism_top_tb.sv
`timescale 1ns/1ps
module pism_top_tb;
    import pism_pkg::*;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic         pready, pslverr, notify_0, notify_1, irq, rerr;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata, rdata;
    logic [11:0]  code_0, code_1;
    logic [127:0] raise = '1;
    logic [127:0] det_en = '1;
    logic [127:0] ack_mask_0 = '0;
    logic [127:0] src_req;
    int           miscompares = 0;
    int           total_checks = 0;
    int           tw [6] = '{0, 1, 1, 2, 2, 3};
    int           tbit [6] = '{0, 31, 0, 29, 0, 8};
    logic [11:0]  tc [6] = '{12'h3E0, 12'h400, 12'h7E0, 12'h840, 12'hBE0,
                             12'hEE0};
    pism_top #(.ADDR_W(8)) pism_top_inst (
        .clk(clk), .arst_n(arst_n), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src_req(src_req),
        .ack_mask_0(ack_mask_0), .ack_mask_1('0),
        .notify_0(notify_0), .notify_1(notify_1),
        .event_vector_code_0(code_0), .event_vector_code_1(code_1),
        .irq(irq)
    );
    pism_periph_model pism_periph_model_inst (
        .clk(clk), .raise(raise), .det_en(det_en), .src_req(src_req)
    );
    initial forever #25 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // psel stays up after a transfer so the next one may follow at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: no answer", $time);
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, e);
    endtask
    // also lets registered notify and irq settle
    task automatic idle();
        psel <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int c = 0; c < 128; c += 64) begin
            for (int w = 0; w < 4; w++) begin
                rd(8'(c + w * 4), VALID_BITS[w]);
                rd(8'(c + 16 + w * 4), ZERO_WORD);
                rd(8'(c + 32 + w * 4), VALID_BITS[w]);
                rd(8'(c + 48 + w * 4), ZERO_WORD);
            end
        end
        apb(1'b1, 8'h04, ZERO_WORD);
        rd(8'h04, VALID_W1);
        apb(1'b1, 8'h34, 32'h8000_0000);
        rd(8'h24, 32'h7FFF_FFFF);
        rd(8'h14, 32'h8000_0000);
        rd(8'h54, ZERO_WORD);
        apb(1'b1, 8'h34, ZERO_WORD);
        rd(8'h24, 32'h7FFF_FFFF);
        idle();
        check({31'h0, notify_0}, 32'h0000_0001);
        check({20'h0, code_0}, 32'h0000_0400);
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, 8'(48 + w * 4), VALID_BITS[w]);
        end
        for (int i = 0; i < 6; i++) begin
            raise <= 128'(1) << (tw[i] * 32 + tbit[i]);
            idle();
            check({20'h0, code_0}, {20'h0, tc[i]});
            rd(8'(16 + tw[i] * 4), 32'h1 << tbit[i]);
        end
        ack_mask_0 <= '1;
        idle();
        check({31'h0, notify_0}, ZERO_WORD);
        rd(8'h1C, ZERO_WORD);
        rd(8'h0C, 32'h0000_0100);
        raise <= 128'(1);
        ack_mask_0 <= '0;
        apb(1'b1, 8'h20, 32'h0000_0001);
        rd(8'h20, 32'h0000_0001);
        rd(8'h10, ZERO_WORD);
        apb(1'b1, 8'h20, ZERO_WORD);
        rd(8'h20, 32'h0000_0001);
        det_en <= '0;
        rd(8'h00, ZERO_WORD);
        rd(OFS_IRQ_ST, 32'h0000_0009);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_000F);
        rd(OFS_IRQ_ST, ZERO_WORD);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0004);
        rd(8'hFC, ZERO_WORD);
        check({31'h0, rerr}, 32'h0000_0001);
        idle();
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, OFS_IRQ_EN, ZERO_WORD);
        idle();
        check({31'h0, irq}, ZERO_WORD);
        // core 1 alone: unmask its watchdog bit
        det_en <= '1;
        apb(1'b1, 8'h70, 32'h0000_0001);
        rd(8'h50, 32'h0000_0001);
        idle();
        check({31'h0, notify_1}, 32'h0000_0001);
        check({20'h0, code_1}, 32'h0000_03E0);
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(8'h24, VALID_W1);
        idle();
        close_out();
    end
endmodule
